// ---- design/ncs_sequencer.sv ----
// nonvolatile configuration sequencer: command list walker between register space and eeprom
`timescale 1ns/1ps
// Summary of operation
// R01 - command list bytes at 0xa00 to 0xaff
// R02 - top bit clear means data transfer
// R03 - low seven bits hold length minus one
// R04 - next two bytes: start address, high first
// R05 - only listed ranges move to or from eeprom
// R06 - top bit set: commit or end of data
// R07 - commit acts like update-all register write
// R08 - end of data stops list, finishes transfer
// R09 - software keeps end code in last byte
// R10 - list resets to save-all then commit contents
// R11 - 0xb00 bit 0 shows transfer in progress
// R12 - progress flag drives status pin when selected
// R13 - 0xb01 bit 0 shows bad data detected
// R14 - 0xb03 bit 0 starts save, self clears
// R15 - saves refused unless 0xb02 bit 0 set
// R16 - software waits 10 us between transfers
// R17 - soft-load bit with select low restores eeprom
// R18 - parse in order, skip two address bytes
// R19 - start clears fault; progress spans commit handling
module ncs_sequencer
  import ncs_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  resetn,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  input  wire logic [REG_AW-1:0]     reg_addr,
  input  wire logic [7:0]            reg_wdata,
  output logic [7:0]                 reg_rdata,
  input  wire logic                  ee_sel_n,
  input  wire logic                  status_src_sel,
  input  wire logic                  status_other,
  output logic                       status_pin,
  output ncs_pkg::ncs_sp_req_type    sp_req,
  input  wire logic [7:0]            sp_rdata,
  output ncs_pkg::ncs_ee_req_type    ee_req,
  input  wire logic                  ee_ack,
  input  wire logic [7:0]            ee_rdata,
  input  wire logic                  ee_err,
  output logic                       update_all,
  output logic                       soft_reset
);
  import ncs_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0]        list_ff [256];
  ncs_state_type     state_ff;
  ncs_state_type     nxt_state;
  logic [7:0]        ptr_ff;
  logic [7:0]        nxt_ptr;
  logic [LEN_MSB:0]  cnt_ff;
  logic [LEN_MSB:0]  nxt_cnt;
  logic [REG_AW-1:0] addr_ff;
  logic [REG_AW-1:0] nxt_addr;
  logic [EE_AW-1:0]  ee_addr_ff;
  logic [EE_AW-1:0]  nxt_ee_addr;
  logic [7:0]        data_ff;
  logic [7:0]        nxt_data;
  logic              load_ff;
  logic              nxt_load;
  logic              busy_ff;
  logic              nxt_busy;
  logic              fault_ff;
  logic              nxt_fault;
  logic              permit_ff;
  logic              save_ff;
  logic              soft_reset_ff;
  logic [7:0]        rdata_ff;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // the list pointer wraps inside the 256-byte region on purpose
  function automatic logic [7:0] list_step(input logic [7:0] base, input logic [7:0] step);
    list_step = 8'(base + step);
  endfunction

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  wire logic       idle       = (state_ff == ST_IDLE);
  wire logic       hit_list   = (reg_addr >= LIST_BASE) && (reg_addr <= LIST_LAST);
  wire logic [7:0] list_idx   = reg_addr[7:0];
  wire logic       wr_list    = reg_wr && hit_list && !busy_ff;
  wire logic       wr_ctrl    = reg_wr && (reg_addr == CTRL_ADDR);
  wire logic       wr_save    = reg_wr && (reg_addr == SAVE_ADDR) && reg_wdata[SAVE_BIT];
  // soft-load only honoured with the eeprom select pin low
  wire logic       start_load = wr_ctrl && reg_wdata[SOFT_LOAD_BIT] && !ee_sel_n && idle; // R17
  // a pending save waits for idle and needs write permission; without it, it is dropped
  wire logic       start_save = save_ff && permit_ff && idle && !start_load; // R14 R15
  wire logic       save_reject = save_ff && !permit_ff && idle; // R15
  wire logic       save_done  = (state_ff == ST_DONE) && !load_ff; // R14

  wire logic [7:0] cmd_byte   = list_ff[ptr_ff];
  wire logic [7:0] adr_hi     = list_ff[list_step(ptr_ff, 8'h01)];
  wire logic [7:0] adr_lo     = list_ff[list_step(ptr_ff, 8'h02)];
  wire logic       is_xfer    = !cmd_byte[OPCODE_BIT]; // R02 R06
  wire logic       is_commit  = (cmd_byte == OP_COMMIT); // R06

  // reads go through a flop so the bus sees a settled byte a cycle later
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (hit_list) begin
      rd_mux = list_ff[list_idx]; // R01
    end else begin
      case (reg_addr)
        PROGRESS_ADDR: rd_mux[FLAG_BIT] = busy_ff; // R11
        FAULT_ADDR:    rd_mux[FLAG_BIT] = fault_ff; // R13
        CTRL_ADDR:     rd_mux[PERMIT_BIT] = permit_ff;
        SAVE_ADDR:     rd_mux[SAVE_BIT] = save_ff;
        default:       rd_mux = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // sequencer next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state   = state_ff;
    nxt_ptr     = ptr_ff;
    nxt_cnt     = cnt_ff;
    nxt_addr    = addr_ff;
    nxt_ee_addr = ee_addr_ff;
    nxt_data    = data_ff;
    nxt_load    = load_ff;
    nxt_busy    = busy_ff;
    nxt_fault   = fault_ff;
    case (state_ff)
      ST_IDLE: begin
        // every pass starts at the list head and at eeprom byte 0
        if (start_load || start_save) begin
          nxt_state   = ST_FETCH;
          nxt_ptr     = 8'h00; // R18
          nxt_ee_addr = '0;
          nxt_load    = start_load;
          nxt_busy    = 1'b1; // R19
          nxt_fault   = 1'b0; // R19
        end
      end
      ST_FETCH: begin
        if (is_xfer) begin
          nxt_cnt   = cmd_byte[LEN_MSB:0]; // R03
          // register space is 12 bits wide; upper nibble of the high byte is dropped
          nxt_addr  = {adr_hi[3:0], adr_lo}; // R04
          nxt_ptr   = list_step(ptr_ff, 8'h03); // R18
          nxt_state = load_ff ? ST_EE : ST_RD; // R05
        end else if (is_commit) begin
          nxt_ptr   = list_step(ptr_ff, 8'h01);
          nxt_state = ST_COMMIT; // R07
        end else begin
          // any other opcode is taken as end of data
          nxt_state = ST_DONE; // R08
        end
      end
      ST_RD: begin
        nxt_state = ST_RDW;
      end
      ST_RDW: begin
        // register space answers the cycle after its read strobe
        nxt_data  = sp_rdata;
        nxt_state = ST_EE;
      end
      ST_EE: begin
        if (ee_ack) begin
          // sticky: a later clean byte must not hide an earlier bad one
          nxt_fault = fault_ff | ee_err; // R13
          if (load_ff) begin
            nxt_data  = ee_rdata;
            nxt_state = ST_WR;
          end else begin
            nxt_state = ST_NEXT;
          end
        end
      end
      ST_WR: begin
        nxt_state = ST_NEXT;
      end
      ST_NEXT: begin
        nxt_ee_addr = EE_AW'(ee_addr_ff + 1'b1);
        // the counter holds length minus one, so zero marks the last byte
        if (cnt_ff == '0) begin
          nxt_state = ST_FETCH;
        end else begin
          nxt_cnt   = (LEN_MSB+1)'(cnt_ff - 1'b1); // R03
          nxt_addr  = REG_AW'(addr_ff + 1'b1); // R05
          nxt_state = load_ff ? ST_EE : ST_RD;
        end
      end
      ST_COMMIT: begin
        nxt_state = ST_FETCH;
      end
      ST_DONE: begin
        // progress drops here, after any commit already issued, and in the default branch
        nxt_busy  = 1'b0; // R19 R08
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
        nxt_busy  = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // flip-flops
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_ff   <= ST_IDLE;
      ptr_ff     <= 8'h00;
      cnt_ff     <= '0;
      addr_ff    <= '0;
      ee_addr_ff <= '0;
      data_ff    <= 8'h00;
      load_ff    <= 1'b0;
      busy_ff    <= 1'b0;
      fault_ff   <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      ptr_ff     <= nxt_ptr;
      cnt_ff     <= nxt_cnt;
      addr_ff    <= nxt_addr;
      ee_addr_ff <= nxt_ee_addr;
      data_ff    <= nxt_data;
      load_ff    <= nxt_load;
      busy_ff    <= nxt_busy;
      fault_ff   <= nxt_fault;
    end
  end

  // list edits are locked out while a transfer walks it
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 256; i++) begin
        list_ff[i] <= ncs_list_default(8'(i)); // R10
      end
    end else if (wr_list) begin
      list_ff[list_idx] <= reg_wdata; // R01
    end
  end

  // permission is looked at only when a save is about to start
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      permit_ff <= PERMIT_RESET; // R15
    end else if (wr_ctrl) begin
      permit_ff <= reg_wdata[PERMIT_BIT];
    end
  end

  // a software set in the same cycle as the hardware clear wins
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      save_ff <= 1'b0;
    end else if (wr_save) begin
      save_ff <= 1'b1; // R14
    end else if (save_done || save_reject) begin
      save_ff <= 1'b0; // R14 R15
    end
  end

  // soft reset is one registered pulse, so it cannot glitch on a decode hazard
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      soft_reset_ff <= 1'b0;
      rdata_ff      <= 8'h00;
    end else begin
      soft_reset_ff <= start_load; // R17
      if (reg_rd) begin
        rdata_ff <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata    = rdata_ff;
  assign soft_reset   = soft_reset_ff;
  assign status_pin   = status_src_sel ? busy_ff : status_other; // R12

  // ----------------------------------------------------------------
  // far-side strobes, decoded straight from the state
  // ----------------------------------------------------------------
  // one-cycle pulse, same effect as a software update-all write
  assign update_all   = (state_ff == ST_COMMIT); // R07
  assign sp_req.rd    = (state_ff == ST_RD);
  assign sp_req.wr    = (state_ff == ST_WR);
  assign sp_req.addr  = addr_ff;
  assign sp_req.wdata = data_ff;
  assign ee_req.req   = (state_ff == ST_EE);
  // eeprom direction follows the kind of transfer latched at start
  assign ee_req.we    = !load_ff;
  assign ee_req.addr  = ee_addr_ff;
  assign ee_req.wdata = data_ff;

endmodule

// ---- design/ncs_pkg.sv ----
// constants, types and default command list of the nonvolatile configuration sequencer
package ncs_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int          REG_AW        = 12;
  localparam int          EE_AW         = 10;
  localparam logic [11:0] LIST_BASE     = 12'ha00;
  localparam logic [11:0] LIST_LAST     = 12'haff;
  localparam logic [11:0] PROGRESS_ADDR = 12'hb00;
  localparam logic [11:0] FAULT_ADDR    = 12'hb01;
  localparam logic [11:0] CTRL_ADDR     = 12'hb02;
  localparam logic [11:0] SAVE_ADDR     = 12'hb03;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int         FLAG_BIT      = 0;
  localparam int         PERMIT_BIT    = 0;
  localparam int         SOFT_LOAD_BIT = 1;
  localparam int         SAVE_BIT      = 0;
  localparam int         OPCODE_BIT    = 7;
  localparam int         LEN_MSB       = 6;
  localparam logic       PERMIT_RESET  = 1'b0;
  localparam logic [7:0] OP_COMMIT     = 8'h80;
  localparam logic [7:0] OP_END        = 8'hff;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0000,
    ST_FETCH  = 4'b0001,
    ST_RD     = 4'b0010,
    ST_RDW    = 4'b0011,
    ST_EE     = 4'b0100,
    ST_WR     = 4'b0101,
    ST_NEXT   = 4'b0110,
    ST_COMMIT = 4'b0111,
    ST_DONE   = 4'b1000
  } ncs_state_type;

  typedef struct packed {
    logic             req;
    logic             we;
    logic [EE_AW-1:0] addr;
    logic [7:0]       wdata;
  } ncs_ee_req_type;

  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [REG_AW-1:0] addr;
    logic [7:0]        wdata;
  } ncs_sp_req_type;

  // default list: four 128-byte ranges, then commit, then end of data
  function automatic logic [7:0] ncs_list_default(input logic [7:0] idx);
    case (idx)
      8'h00, 8'h03, 8'h06, 8'h09: ncs_list_default = 8'h7f;
      8'h05, 8'h0b:               ncs_list_default = 8'h80;
      8'h07, 8'h0a:               ncs_list_default = 8'h01;
      8'h0c:                      ncs_list_default = OP_COMMIT;
      8'h01, 8'h02, 8'h04, 8'h08: ncs_list_default = 8'h00;
      default:                    ncs_list_default = OP_END;
    endcase
  endfunction

endpackage

// ---- sim/ncs_far_model.sv ----
// register space and eeprom model on the far side of the sequencer
`timescale 1ns/1ps
module ncs_far_model
  import ncs_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              resetn,
  input  ncs_pkg::ncs_sp_req_type sp_req,
  input  ncs_pkg::ncs_ee_req_type ee_req,
  input  wire logic              slow,
  input  wire logic              inj_err,
  output logic [7:0]             sp_rdata,
  output logic                   ee_ack,
  output logic [7:0]             ee_rdata,
  output logic                   ee_err
);
  logic [7:0] regs [4096];
  logic [7:0] ee_mem [1024];
  logic [1:0] wait_ff;
  // ----------------------------------------------------------------
  // behaviour
  // ----------------------------------------------------------------
  // data outside the ack cycle is inverted so a late sample cannot match
  assign ee_rdata = ee_ack ? ee_mem[ee_req.addr] : ~ee_mem[ee_req.addr];
  assign ee_err   = inj_err;
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sp_rdata <= 8'h00;
      ee_ack   <= 1'b0;
      wait_ff  <= 2'h0;
    end else begin
      sp_rdata <= sp_req.rd ? regs[sp_req.addr] : ~sp_rdata;
      if (sp_req.wr) regs[sp_req.addr] <= sp_req.wdata;
      if (ee_ack && ee_req.we) ee_mem[ee_req.addr] <= ee_req.wdata;
      // slow mode stretches every eeprom access by three cycles
      ee_ack  <= ee_req.req && !ee_ack && (wait_ff == 2'h3 || !slow);
      wait_ff <= (ee_req.req && !ee_ack) ? wait_ff + 2'h1 : 2'h0;
    end
  end
endmodule

// ---- sim/ncs_chk.sv ----
// port assertions of the configuration sequencer
`timescale 1ns/1ps
module ncs_chk
  import ncs_pkg::*;
(
  input wire logic              clock,
  input wire logic              resetn,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [REG_AW-1:0] reg_addr,
  input wire logic [7:0]        reg_wdata,
  input wire logic [7:0]        reg_rdata,
  input wire logic              ee_sel_n,
  input wire logic              status_src_sel,
  input wire logic              status_other,
  input wire logic              status_pin,
  input ncs_pkg::ncs_sp_req_type sp_req,
  input wire logic [7:0]        sp_rdata,
  input ncs_pkg::ncs_ee_req_type ee_req,
  input wire logic              ee_ack,
  input wire logic [7:0]        ee_rdata,
  input wire logic              ee_err,
  input wire logic              update_all,
  input wire logic              soft_reset
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence s_rd_to_ee;
    ##2 (ee_req.req && ee_req.we && ee_req.wdata == $past(sp_rdata));
  endsequence
  a_status_bypass: assert property (!status_src_sel |-> status_pin == status_other)
    else $error("status pin not bypassed");
  a_progress_read: assert property (reg_rd && reg_addr == PROGRESS_ADDR && status_src_sel
    |=> reg_rdata == {7'h00, $past(status_pin)}) else $error("progress read wrong");
  a_fault_upper: assert property (reg_rd && reg_addr == FAULT_ADDR |=> reg_rdata[7:1] == 7'h00)
    else $error("fault upper bits set");
  a_soft_cause: assert property (soft_reset |->
    $past(reg_wr && reg_addr == CTRL_ADDR && reg_wdata[SOFT_LOAD_BIT] && !ee_sel_n))
    else $error("soft reset without cause");
  a_soft_once: assert property (soft_reset |=> !soft_reset) else $error("soft reset too long");
  a_commit_once: assert property (update_all |=> !update_all) else $error("commit too long");
  a_ee_hold: assert property (ee_req.req && !ee_ack |=> ee_req.req && $stable(ee_req.addr))
    else $error("eeprom request dropped");
  a_load_write: assert property (sp_req.wr |-> $past(ee_ack && !ee_req.we)
    && sp_req.wdata == $past(ee_rdata)) else $error("load data wrong");
  a_save_path: assert property (sp_req.rd |-> s_rd_to_ee) else $error("save data wrong");
endmodule
bind ncs_sequencer ncs_chk u_chk (.clock(clock), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ee_sel_n(ee_sel_n),
  .status_src_sel(status_src_sel), .status_other(status_other), .status_pin(status_pin),
  .sp_req(sp_req), .sp_rdata(sp_rdata), .ee_req(ee_req), .ee_ack(ee_ack), .ee_rdata(ee_rdata),
  .ee_err(ee_err), .update_all(update_all), .soft_reset(soft_reset));

// ---- sim/ncs_sequencer_bench.sv ----
// self-checking bench of the configuration sequencer
`timescale 1ns/1ps
module ncs_sequencer_bench;
  import ncs_pkg::*;
  logic        clock, resetn, reg_wr, reg_rd, ee_sel_n, status_src_sel, status_other;
  logic        slow, inj_err, status_pin, ee_ack, ee_err, update_all, soft_reset;
  logic [11:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, sp_rdata, ee_rdata, v;
  ncs_sp_req_type sp_req;
  ncs_ee_req_type ee_req;
  int          num_errors, checks_done, commits, cycles;
  // reset contents of the list, control reads and an unmapped address
  localparam logic [19:0] rows [20] = '{20'ha007f, 20'ha0100, 20'ha0200, 20'ha037f, 20'ha0400,
    20'ha0580, 20'ha067f, 20'ha0701, 20'ha0800, 20'ha097f, 20'ha0a01, 20'ha0b80, 20'ha0c80,
    20'ha0dff, 20'haffff, 20'hb0000, 20'hb0100, 20'hb0200, 20'hb0300, 20'hc0000};
  localparam logic [7:0] load_list [5] = '{8'h01, 8'h01, 8'h23, OP_COMMIT, OP_END};
  ncs_sequencer dut (.clock(clock), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ee_sel_n(ee_sel_n),
    .status_src_sel(status_src_sel), .status_other(status_other), .status_pin(status_pin),
    .sp_req(sp_req), .sp_rdata(sp_rdata), .ee_req(ee_req), .ee_ack(ee_ack), .ee_rdata(ee_rdata),
    .ee_err(ee_err), .update_all(update_all), .soft_reset(soft_reset));
  ncs_far_model far (.clock(clock), .resetn(resetn), .sp_req(sp_req), .ee_req(ee_req), .slow(slow),
    .inj_err(inj_err), .sp_rdata(sp_rdata), .ee_ack(ee_ack), .ee_rdata(ee_rdata), .ee_err(ee_err));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t %s got %h", $time, msg, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clock);
    #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clock);
    #1;
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge clock);
    #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clock);
    #1;
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
  task automatic wait_idle();
    v = 8'h01;
    for (int i = 0; i < 400 && v !== 8'h00; i++) rd(PROGRESS_ADDR, v);
    chk(v, 8'h00, "transfer never ended");
    repeat (1000) @(posedge clock);
  endtask
  task automatic report_and_stop();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // clock, watchdog and commit counter
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (update_all === 1'b1) commits++;
    // whole run needs about 3100 cycles
    if (cycles == 30000) begin
      num_errors++;
      report_and_stop();
    end
  end
  initial begin
    {resetn, reg_wr, reg_rd, status_src_sel, slow, inj_err} = 6'h00;
    {ee_sel_n, status_other, reg_addr, reg_wdata} = 22'h200000;
    {num_errors, checks_done, commits, cycles} = 0;
    repeat (6) @(posedge clock);
    #1;
    resetn = 1'b1;
    foreach (rows[i]) begin
      rd(rows[i][19:8], v);
      chk(v, rows[i][7:0], "reset read");
    end
    // load two bytes to 0x123 with a fault, then again without one
    foreach (load_list[i]) wr(LIST_BASE + 12'(i), load_list[i]);
    far.ee_mem[0] = 8'h3c;
    far.ee_mem[1] = 8'hc5;
    far.regs[12'h125] = 8'h77;
    ee_sel_n = 1'b0;
    inj_err = 1'b1;
    wr(CTRL_ADDR, 8'h02);
    chk({7'h00, soft_reset}, 8'h01, "no soft reset");
    wait_idle();
    chk(far.regs[12'h123], 8'h3c, "load byte 0");
    chk(far.regs[12'h124], 8'hc5, "load byte 1");
    chk(far.regs[12'h125], 8'h77, "load overrun");
    chk(8'(commits), 8'h01, "commit count");
    rd(FAULT_ADDR, v);
    chk(v, 8'h01, "fault not flagged");
    inj_err = 1'b0;
    wr(CTRL_ADDR, 8'h02);
    wait_idle();
    rd(FAULT_ADDR, v);
    chk(v, 8'h00, "fault not cleared");
    chk(8'(commits), 8'h02, "second commit");
    // save of one byte at 0x010, first refused while protected
    ee_sel_n = 1'b1;
    far.regs[12'h010] = 8'h5a;
    wr(LIST_BASE, 8'h00);
    wr(LIST_BASE + 12'h001, 8'h00);
    wr(LIST_BASE + 12'h002, 8'h10);
    wr(LIST_BASE + 12'h003, OP_END);
    wr(SAVE_ADDR, 8'h01);
    repeat (4) @(posedge clock);
    rd(SAVE_ADDR, v);
    chk(v, 8'h00, "refused save stuck");
    chk(far.ee_mem[0], 8'h3c, "protected write");
    slow = 1'b1;
    status_src_sel = 1'b1;
    wr(CTRL_ADDR, 8'h01);
    wr(SAVE_ADDR, 8'h01);
    // the pending save starts one edge after the bit is stored
    @(posedge clock);
    #1;
    chk({7'h00, status_pin}, 8'h01, "pin not busy");
    rd(SAVE_ADDR, v);
    chk(v, 8'h01, "save bit early clear");
    wait_idle();
    chk(far.ee_mem[0], 8'h5a, "saved byte");
    chk(far.ee_mem[1], 8'hc5, "save overrun");
    rd(SAVE_ADDR, v);
    chk(v, 8'h00, "save bit stays");
    chk({7'h00, status_pin}, 8'h00, "pin still busy");
    // reset after the save has finished brings the edited list back to its default contents
    status_src_sel = 1'b0;
    status_other = 1'b1;
    resetn = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk({7'h00, status_pin}, 8'h01, "pin not bypassed");
    resetn = 1'b1;
    rd(LIST_BASE, v);
    chk(v, 8'h7f, "list head not restored");
    rd(LIST_BASE + 12'h003, v);
    chk(v, 8'h7f, "edited entry not restored");
    rd(CTRL_ADDR, v);
    chk(v, 8'h00, "permit not cleared");
    report_and_stop();
  end
endmodule
